/* File: scfg_board.sv */
// Board model: strap resistors, lamp wiring and pairing button
`timescale 1ns/1ns
module scfg_board (
  // Board strap levels and button
  input wire logic [10:0] strap,
  input wire logic press,
  // Module pin drive
  input wire logic [10:0] pin_o,
  input wire logic [10:0] pin_oe,
  // Resolved pin levels
  output logic [10:0] pin_i
);
  // ------------------------------------------------------------------
  // Pin resolution
  // ------------------------------------------------------------------
  always_comb begin
    for (int b = 0; b < 11; b++) begin
      // Released pins settle to the strap resistor, never a stale drive
      pin_i[b] = pin_oe[b] ? strap[b] : pin_o[b];
    end
    // Button pulls against its resting strap level
    if (press && pin_oe[1]) begin
      pin_i[1] = ~strap[1];
    end
  end
endmodule

/* File: scfg_lamp.sv */
// One status lamp driver with on, off and flash modes and strap polarity
`timescale 1ns/1ns
module scfg_lamp #(
  parameter int HALF_CYC = 2_500_000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Control
  input wire logic [1:0] mode,
  input wire logic strap_level,
  input wire logic flash_phase,
  // Pin drive
  output logic lamp_out
);
  import scfg_pkg::*;

  logic next_lamp_out;
  logic lit;

  always_comb begin
    lit = 1'b0;
    case (mode)
      LAMP_ON: lit = 1'b1;
      LAMP_FLASH: lit = flash_phase;
      default: lit = 1'b0;
    endcase
    // A pin strapped high has its lamp wired to the supply, so lit means low
    next_lamp_out = lit ^ strap_level;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      lamp_out <= 1'b0;
    end else begin
      lamp_out <= next_lamp_out;
    end
  end
endmodule

/* File: scfg_pkg.sv */
// Package for the strap configuration and status indicator block
package scfg_pkg;

  // ------------------------------------------------------------------
  // Wishbone register map (word aligned byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_STRAP = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_LAMP = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IDENT = 8'h10;
  // Arbitrary neutral identification value
  localparam logic [31:0] IDENT_VALUE = 32'h5c0f_0001;

  // ------------------------------------------------------------------
  // Strap capture bit positions (11 shared pins)
  // ------------------------------------------------------------------
  localparam int NUM_PINS = 11;
  localparam int BIT_DUPLEX = 0;
  localparam int BIT_IFACE_SEL = 1;
  localparam int BIT_AUTONEG = 2;
  localparam int BIT_ISOLATE = 3;
  localparam int BIT_SPEED0 = 4;
  localparam int BIT_SPEED1 = 5;
  localparam int BIT_ADDR3 = 6;
  localparam int BIT_ADDR4 = 7;
  localparam int BIT_ROLE = 8;
  localparam int BIT_LED_ETH = 9;
  localparam int BIT_LED_MODE = 10;

  // Pin defaults (internal pull levels) used while reset is held
  localparam logic [10:0] STRAP_RESET = 11'h757;

  // ------------------------------------------------------------------
  // Decoded values
  // ------------------------------------------------------------------
  localparam logic [1:0] SPEED_10 = 2'h0;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;
  localparam logic [1:0] SPEED_RSVD = 2'h3;
  localparam logic [4:0] MGMT_ADDR_STEP = 5'h08;

  // Lamp mode encodings written by firmware
  localparam logic [1:0] LAMP_OFF = 2'h0;
  localparam logic [1:0] LAMP_ON = 2'h1;
  localparam logic [1:0] LAMP_FLASH = 2'h2;

  // Flash half period: 250 ms at 10 MHz
  localparam int CLK_HZ = 10_000_000;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;

  // Button debounce: 20 ms
  localparam int DEBOUNCE_MS = 20;
  localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic phy_role;
    logic [1:0] speed;
    logic [4:0] mgmt_addr;
    logic autoneg;
    logic full_duplex;
    logic isolate;
  } scfg_cfg_type;

  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } scfg_wbreq_type;

  typedef enum logic [2:0] {
    ST_RESET = 3'h1,
    ST_CAPTURE = 3'h2,
    ST_RUN = 3'h4
  } scfg_state_type;

endpackage

/* File: scfg_top.sv */
// Strap capture, configuration decode, lamps, button and register slave
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ns
module scfg_top #(
  parameter int FLASH_CYC = scfg_pkg::FLASH_HALF_CYC,
  parameter int DEBOUNCE = scfg_pkg::DEBOUNCE_CYC,
  parameter logic RGMII_VARIANT = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Wishbone slave
  input wire scfg_pkg::scfg_wbreq_type wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Shared strap pins: input, output, output enable (low drives)
  input wire logic [10:0] strap_pin_i,
  output logic [10:0] strap_pin_o,
  output logic [10:0] strap_pin_oe,
  // Decoded configuration to the Ethernet core
  output scfg_pkg::scfg_cfg_type cfg,
  output logic mii_release,
  output logic pair_request
);
  import scfg_pkg::*;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [10:0] pin_meta;
  logic [10:0] pin_sync;
  always_ff @(posedge sys_clk) begin
    pin_meta <= strap_pin_i;
    pin_sync <= pin_meta;
  end

  // ------------------------------------------------------------------
  // Capture sequence
  // ------------------------------------------------------------------
  scfg_state_type state, next_state;
  logic [10:0] strap, next_strap;

  always_comb begin
    next_state = state;
    next_strap = strap;
    case (state)
      // Two cycles let the synchroniser fill with out-of-reset pin levels
      ST_RESET: next_state = ST_CAPTURE;
      ST_CAPTURE: begin
        next_strap = pin_sync;
        next_state = ST_RUN;
      end
      ST_RUN: next_state = ST_RUN;
      default: next_state = ST_RESET;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state <= ST_RESET;
      strap <= STRAP_RESET;
    end else begin
      state <= next_state;
      strap <= next_strap;
    end
  end

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  function automatic logic [4:0] mgmt_decode(input logic [1:0] s);
    mgmt_decode = 5'(s) * MGMT_ADDR_STEP;
  endfunction

  scfg_cfg_type next_cfg;
  logic next_release;
  always_comb begin
    next_cfg = '0;
    next_cfg.phy_role = ~strap[BIT_ROLE];
    if (next_cfg.phy_role) begin
      next_cfg.speed = RGMII_VARIANT ? SPEED_1000 :
        {strap[BIT_SPEED1], strap[BIT_SPEED0]};
      next_cfg.mgmt_addr =
        mgmt_decode({strap[BIT_ADDR4], strap[BIT_ADDR3]});
      next_cfg.autoneg = strap[BIT_AUTONEG];
      next_cfg.full_duplex = RGMII_VARIANT | strap[BIT_DUPLEX];
      next_cfg.isolate = strap[BIT_ISOLATE];
    end else begin
      // Host role: own defaults, address straps ignored
      next_cfg.speed = RGMII_VARIANT ? SPEED_1000 : SPEED_100;
      next_cfg.mgmt_addr = MGMT_ADDR_STEP;
      next_cfg.autoneg = 1'b1;
      next_cfg.full_duplex = 1'b1;
      next_cfg.isolate = 1'b0;
    end
    // Outputs released to high impedance while isolated or not yet captured
    next_release = next_cfg.isolate | (state != ST_RUN);
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cfg <= '0;
      mii_release <= 1'b1;
    end else begin
      cfg <= next_cfg;
      mii_release <= next_release;
    end
  end

  // ------------------------------------------------------------------
  // Flash timebase and lamps
  // ------------------------------------------------------------------
  logic [31:0] flash_cnt, next_flash_cnt;
  logic flash_phase, next_flash_phase;
  always_comb begin
    next_flash_cnt = flash_cnt + 32'h1;
    next_flash_phase = flash_phase;
    if (flash_cnt >= 32'(FLASH_CYC - 1)) begin
      next_flash_cnt = '0;
      next_flash_phase = ~flash_phase;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      flash_cnt <= '0;
      flash_phase <= 1'b0;
    end else begin
      flash_cnt <= next_flash_cnt;
      flash_phase <= next_flash_phase;
    end
  end

  // Lamp register: [1:0] power, [3:2] eth, [5:4] mode, [7:6] line link
  logic [7:0] lamp_reg, next_lamp_reg;
  logic [1:0] lamp_mode [4];
  logic [3:0] lamp_drive;
  localparam int LAMP_PIN [4] = '{BIT_SPEED1, BIT_LED_ETH, BIT_LED_MODE,
    BIT_ROLE};

  always_comb begin
    lamp_mode[0] = lamp_reg[1:0];
    lamp_mode[1] = lamp_reg[3:2];
    // Mode lamp has no flashing state
    lamp_mode[2] = (lamp_reg[5:4] == LAMP_ON) ? LAMP_ON : LAMP_OFF;
    lamp_mode[3] = lamp_reg[7:6];
  end

  for (genvar i = 0; i < 4; i++) begin : g_lamp
    scfg_lamp #(.HALF_CYC(FLASH_CYC)) u_lamp (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .mode(lamp_mode[i]),
      .strap_level(strap[LAMP_PIN[i]]),
      .flash_phase(flash_phase),
      .lamp_out(lamp_drive[i])
    );
  end

  // Pins float during capture, lamps drive only after it
  logic [10:0] next_pin_o, next_pin_oe;
  always_comb begin
    next_pin_o = '0;
    next_pin_oe = '1;
    if (state == ST_RUN) begin
      for (int i = 0; i < 4; i++) begin
        next_pin_o[LAMP_PIN[i]] = lamp_drive[i];
        next_pin_oe[LAMP_PIN[i]] = 1'b0;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      strap_pin_o <= '0;
      strap_pin_oe <= '1;
    end else begin
      strap_pin_o <= next_pin_o;
      strap_pin_oe <= next_pin_oe;
    end
  end

  // ------------------------------------------------------------------
  // Pairing button
  // ------------------------------------------------------------------
  logic btn_pressed;
  logic [31:0] deb_cnt, next_deb_cnt;
  logic btn_stable, next_btn_stable;
  logic next_pair;
  logic pair_sticky, next_pair_sticky;
  logic ack_clr;

  // Resting level equals the captured strap; pressing drives the other way
  assign btn_pressed = (pin_sync[BIT_IFACE_SEL] != strap[BIT_IFACE_SEL]);

  always_comb begin
    next_deb_cnt = '0;
    next_btn_stable = btn_stable;
    if (state == ST_RUN && btn_pressed != btn_stable) begin
      next_deb_cnt = deb_cnt + 32'h1;
      if (deb_cnt >= 32'(DEBOUNCE - 1)) begin
        next_deb_cnt = '0;
        next_btn_stable = btn_pressed;
      end
    end
    next_pair = next_btn_stable & ~btn_stable;
    // Set wins over a software clear in the same cycle
    next_pair_sticky = (pair_sticky & ~ack_clr) | next_pair;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      deb_cnt <= '0;
      btn_stable <= 1'b0;
      pair_request <= 1'b0;
      pair_sticky <= 1'b0;
    end else begin
      deb_cnt <= next_deb_cnt;
      btn_stable <= next_btn_stable;
      pair_request <= next_pair;
      pair_sticky <= next_pair_sticky;
    end
  end

  // ------------------------------------------------------------------
  // Wishbone slave, one wait state, ack for one cycle
  // ------------------------------------------------------------------
  logic req;
  logic [31:0] next_dat;
  logic next_ack;
  assign req = wb_req.cyc & wb_req.stb & ~wb_ack_o;
  assign ack_clr = req & wb_req.we & (wb_req.adr[7:0] == ADDR_STATUS) &
    wb_req.sel[0] & wb_req.dat[0];

  always_comb begin
    next_ack = req;
    next_lamp_reg = lamp_reg;
    next_dat = '0;
    if (req && wb_req.we && wb_req.adr[7:0] == ADDR_LAMP &&
        wb_req.sel[0]) begin
      next_lamp_reg = wb_req.dat[7:0];
    end
    if (req && !wb_req.we) begin
      case (wb_req.adr[7:0])
        ADDR_STRAP: next_dat = {21'h0, strap};
        ADDR_CONFIG: next_dat = {21'h0, cfg};
        ADDR_LAMP: next_dat = {24'h0, lamp_reg};
        ADDR_STATUS: next_dat = {29'h0, btn_stable, mii_release,
          pair_sticky};
        ADDR_IDENT: next_dat = IDENT_VALUE;
        default: next_dat = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      lamp_reg <= '0;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      lamp_reg <= next_lamp_reg;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  strap_hold_a: assert property (
    (state == ST_RUN) |=> (strap == $past(strap)))
    else $error("strap changed after capture");
  strap_take_a: assert property (
    (state == ST_CAPTURE) |=> (strap == $past(pin_sync)))
    else $error("strap not taken at capture");
  role_decode_a: assert property (
    (state == ST_RUN) |=> (cfg.phy_role == ~strap[BIT_ROLE]))
    else $error("role decode wrong");
  addr_decode_a: assert property (
    (state == ST_RUN && !strap[BIT_ROLE]) |=>
    (cfg.mgmt_addr == {strap[BIT_ADDR4], strap[BIT_ADDR3], 3'h0}))
    else $error("address decode wrong");
  mac_ignore_a: assert property (
    (state == ST_RUN && strap[BIT_ROLE]) |=>
    (!cfg.isolate && cfg.autoneg && cfg.mgmt_addr == MGMT_ADDR_STEP))
    else $error("strap applied in host role");
  isolate_out_a: assert property (
    cfg.isolate |-> mii_release)
    else $error("isolated but not released");
  mode_noflash_a: assert property (
    (state == ST_RUN && lamp_reg[5:4] == LAMP_FLASH) |=> ##1
    (strap_pin_o[BIT_LED_MODE] == strap[BIT_LED_MODE]))
    else $error("mode lamp lit while flash requested");
  // Ack rises for exactly one cycle after each accepted request
  sequence ack_pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  wb_ack_a: assert property (
    (req && !wb_ack_o) |=> ack_pulse_s)
    else $error("bus ack not a single cycle");
endmodule

/* File: tb_strap_config_and_status_indicators.sv */
// Testbench for strap capture, decode, lamps and pairing button
`timescale 1ns/1ns
module tb_strap_config_and_status_indicators;
  import scfg_pkg::*;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic sys_clk;
  logic rstn;
  scfg_wbreq_type req;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [10:0] pin_i;
  logic [10:0] pin_o;
  logic [10:0] pin_oe;
  scfg_cfg_type cfg;
  scfg_cfg_type cfg_rg;
  logic mii_release;
  logic pair_request;
  logic [10:0] strap;
  logic press;
  logic [31:0] rd;
  int mismatches;
  int checks_done;

  // Short counts keep flash and debounce visible in a brief run
  scfg_top #(.FLASH_CYC(8), .DEBOUNCE(4), .RGMII_VARIANT(1'b0)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .wb_req(req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .strap_pin_i(pin_i), .strap_pin_o(pin_o),
    .strap_pin_oe(pin_oe), .cfg(cfg), .mii_release(mii_release),
    .pair_request(pair_request));
  scfg_board board (.strap(strap), .press(press), .pin_o(pin_o),
    .pin_oe(pin_oe), .pin_i(pin_i));
  // Second copy built as the RGMII variant, capturing the same pins
  scfg_top #(.FLASH_CYC(8), .DEBOUNCE(4), .RGMII_VARIANT(1'b1)) dut_rgmii (
    .sys_clk(sys_clk), .rstn(rstn), .wb_req(req), .wb_dat_o(),
    .wb_ack_o(), .strap_pin_i(pin_i), .strap_pin_o(),
    .strap_pin_oe(), .cfg(cfg_rg), .mii_release(),
    .pair_request());

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic stop_test();
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wb(input logic [7:0] a, input logic we,
                    input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{adr: {24'h0, a}, dat: d, sel: 4'hf, we: we, cyc: 1'b1,
             stb: 1'b1};
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    req <= '0;
    @(posedge sys_clk);
  endtask

  task automatic reset_with(input logic [10:0] s);
    @(posedge sys_clk);
    rstn <= 1'b0;
    strap <= s;
    repeat (16) @(posedge sys_clk);
    chk("rst_release", 32'(mii_release), 32'h1);
    chk("rst_oe", 32'(pin_oe), 32'h7ff);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic pulses(input int cyc, output int n);
    n = 0;
    repeat (cyc) begin
      @(posedge sys_clk);
      if (pair_request === 1'b1) n++;
    end
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic test_phy();
    logic [10:0] s;
    for (int i = 0; i < 4; i++) begin
      s = STRAP_RESET;
      s[BIT_ROLE] = 1'b0;
      {s[BIT_SPEED1], s[BIT_SPEED0]} = 2'(i);
      {s[BIT_ADDR4], s[BIT_ADDR3]} = 2'(i);
      s[BIT_AUTONEG] = s[BIT_SPEED0];
      s[BIT_DUPLEX] = s[BIT_SPEED1];
      s[BIT_ISOLATE] = s[BIT_SPEED0];
      reset_with(s);
      chk("phy_role", 32'(cfg.phy_role), 32'h1);
      chk("speed", 32'(cfg.speed), 32'(i));
      chk("mgmt_addr", 32'(cfg.mgmt_addr), 32'(i * 8));
      chk("autoneg", 32'(cfg.autoneg), 32'(i % 2));
      chk("duplex", 32'(cfg.full_duplex), 32'(i / 2));
      chk("isolate", 32'(cfg.isolate), 32'(i % 2));
      chk("release", 32'(mii_release), 32'(i % 2));
      chk("rg_speed", 32'(cfg_rg.speed), 32'(SPEED_1000));
      chk("rg_duplex", 32'(cfg_rg.full_duplex), 32'h1);
      wb(ADDR_CONFIG, 1'b0, 32'h0);
      chk("cfg_reg", rd, 32'({1'b1, s[5], s[4], s[7], s[6], 3'h0,
          s[2], s[0], s[3]}));
    end
  endtask

  task automatic test_mac();
    logic [10:0] s;
    // Host role: duplex left at its pull-up, button pin strapped high
    s = 11'h103;
    reset_with(s);
    chk("mac_speed", 32'(cfg.speed), 32'(SPEED_100));
    chk("rg_mac_speed", 32'(cfg_rg.speed), 32'(SPEED_1000));
    wb(ADDR_CONFIG, 1'b0, 32'h0);
    chk("mac_cfg", rd, 32'({1'b0, SPEED_100, 5'h08, 3'h6}));
    chk("mac_release", 32'(mii_release), 32'h0);
    // Later pin activity must not disturb the captured set
    strap <= s ^ 11'h0dd;
    repeat (6) @(posedge sys_clk);
    wb(ADDR_STRAP, 1'b1, 32'h7ff);
    wb(ADDR_STRAP, 1'b0, 32'h0);
    chk("strap_reg", rd, 32'(s));
    chk("cfg_hold", 32'(cfg), 32'({1'b0, SPEED_100, 5'h08, 3'h6}));
    wb(8'h14, 1'b0, 32'h0);
    chk("unmapped", rd, 32'h0);
    wb(ADDR_IDENT, 1'b0, 32'h0);
    chk("ident", rd, IDENT_VALUE);
  endtask

  task automatic test_lamps();
    int sh[3] = '{0, 2, 6};
    int pn[3] = '{5, 9, 8};
    int t;
    logic last;
    wb(ADDR_LAMP, 1'b1, 32'h55);
    repeat (3) @(posedge sys_clk);
    chk("lamp_on", 32'({pin_o[10:8], pin_o[5]}), 32'hd);
    chk("lamp_oe", 32'({pin_oe[10:8], pin_oe[5]}), 32'h0);
    wb(ADDR_LAMP, 1'b0, 32'h0);
    chk("lamp_reg", rd, 32'h55);
    wb(ADDR_LAMP, 1'b1, 32'h20);
    t = 0;
    repeat (24) begin
      @(posedge sys_clk);
      if (pin_o[10] !== 1'b0) t++;
    end
    chk("mode_flash", 32'(t), 32'h0);
    chk("lamp_off", 32'({pin_o[9:8], pin_o[5]}), 32'h2);
    for (int k = 0; k < 3; k++) begin
      wb(ADDR_LAMP, 1'b1, 32'h2 << sh[k]);
      t = 0;
      last = pin_o[pn[k]];
      repeat (24) begin
        @(posedge sys_clk);
        if (pin_o[pn[k]] !== last) t++;
        last = pin_o[pn[k]];
      end
      chk("flash", 32'(t >= 2 && t <= 4), 32'h1);
    end
  endtask

  task automatic test_button();
    int n;
    press <= 1'b1;
    pulses(30, n);
    chk("pair_press", 32'(n), 32'h1);
    wb(ADDR_STATUS, 1'b0, 32'h0);
    chk("pair_sticky", rd & 32'h7, 32'h5);
    wb(ADDR_STATUS, 1'b1, 32'h1);
    wb(ADDR_STATUS, 1'b0, 32'h0);
    chk("pair_clear", rd & 32'h1, 32'h0);
    press <= 1'b0;
    pulses(30, n);
    chk("pair_release", 32'(n), 32'h0);
  endtask

  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    req = '0;
    strap = STRAP_RESET;
    press = 1'b0;
    mismatches = 0;
    checks_done = 0;
    reset_with(STRAP_RESET);
    chk("default_role", 32'(cfg.phy_role), 32'h0);
    test_phy();
    test_mac();
    test_lamps();
    test_button();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    stop_test();
  end
endmodule
